// *** cpf_consts.svh ***
// Constants for the pointer and flag register block
`ifndef CPF_CONSTS_SVH
`define CPF_CONSTS_SVH

// Register word addresses on the register port
`define CPF_OFS_SP 8'h00
`define CPF_OFS_PC 8'h04
`define CPF_OFS_CCR 8'h08
`define CPF_OFS_HX 8'h0c
`define CPF_OFS_STAT 8'h10

// Reset values
`define CPF_SP_RESET 16'h00ff
`define CPF_SP_LOW_RESET 8'hff
`define CPF_H_RESET 8'h00
`define CPF_CCR_RESET 8'h68

// Condition flag bit positions
`define CPF_BIT_V 7
`define CPF_BIT_ONE6 6
`define CPF_BIT_ONE5 5
`define CPF_BIT_H 4
`define CPF_BIT_I 3
`define CPF_BIT_N 2
`define CPF_BIT_Z 1
`define CPF_BIT_C 0
`define CPF_CCR_ONES 8'h60

// Reset vector location, high byte first
`define CPF_VEC_HI 16'hfffe
`define CPF_VEC_LO 16'hffff

// Status register bit positions
`define CPF_STAT_VEC_BUSY 0
`define CPF_STAT_IRQ_HOLD 1
`define CPF_STAT_IRQ_TAKE 2

`endif

// *** cpf_pkg.sv ***
// Types shared by the pointer and flag register block
package cpf_pkg;

	// Flag update operations of the arithmetic unit
	typedef enum logic [3:0] {
		ALU_NONE, ALU_ADD, ALU_ADC, ALU_SUB, ALU_DADJ,
		ALU_LD8, ALU_LD16, ALU_SHL, ALU_SHR, ALU_BTST
	} cpf_alu_e;

	// Operand addressing modes
	typedef enum logic [3:0] {
		AM_DIR, AM_EXT, AM_IX, AM_IXP, AM_IX1, AM_IX1P,
		AM_IX2, AM_SP1, AM_SP2, AM_REL
	} cpf_mode_e;

	// Register port decode result
	typedef enum logic [2:0] {
		SEL_SP, SEL_PC, SEL_CCR, SEL_HX, SEL_STAT, SEL_NONE
	} cpf_sel_e;

	// Five result flags
	typedef struct packed {
		logic v;
		logic h;
		logic n;
		logic z;
		logic c;
	} cpf_flags_s;

	// Per-cycle command from the instruction sequencer
	typedef struct packed {
		logic fetch;
		logic cof_load;
		logic [15:0] cof_target;
		logic rel_take;
		logic sp_adjust;
		logic sp_low_reset;
		logic sp_push;
		logic sp_pull;
		logic [7:0] imm8;
		logic [15:0] imm16;
		logic [7:0] dst_off8;
		cpf_alu_e alu_op;
		logic [7:0] alu_a;
		logic [7:0] alu_b;
		logic [15:0] alu_w;
		logic mask_set;
		logic mask_clear;
		logic ccr_load;
		logic [7:0] ccr_wdata;
		logic irq_pushed;
		logic boundary;
		logic x_load;
		logic [7:0] x_wdata;
		logic h_load;
		logic [7:0] h_wdata;
		cpf_mode_e src_mode;
		cpf_mode_e dst_mode;
		logic ea_done;
	} cpf_cmd_s;

	// Visible state returned to the sequencer
	typedef struct packed {
		logic [15:0] pc;
		logic [15:0] sp;
		logic [7:0] condition_flags_reg;
		logic [15:0] hx;
		logic [7:0] alu_res;
		logic [15:0] src_addr;
		logic [15:0] dst_addr;
		logic vec_busy;
	} cpf_view_s;

endpackage

// *** cpf_flag_unit.sv ***
// Arithmetic result and condition flag generation
`timescale 1ns/1ps
`default_nettype none
module cpf_flag_unit import cpf_pkg::*; (
	input wire cpf_alu_e op,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic [15:0] w,
	input wire cpf_flags_s flags_in,
	output logic [7:0] res,
	output cpf_flags_s flags_out
);
	// Carry in only for add with carry
	wire cin = (op == ALU_ADC) ? flags_in.c : 1'b0;
	// Nine-bit sum and difference
	wire [8:0] sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
	wire [8:0] dif9 = {1'b0, a} - {1'b0, b};
	// Low nibble sum for the half carry
	wire [4:0] nib5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
	// Decimal correction terms
	wire dadj_hi = flags_in.c | (a > 8'h99);
	wire dadj_lo = flags_in.h | (a[3:0] > 4'h9);
	wire [7:0] dadj_add = {1'b0, dadj_hi, dadj_hi, 2'b00, dadj_lo, dadj_lo, 1'b0};

	// Result and flag selection per operation
	always_comb begin
		res = a;
		flags_out = flags_in;
		case (op)
			ALU_ADD, ALU_ADC: begin
				res = sum9[7:0];
				flags_out.h = nib5[4]; // RULE10
				flags_out.c = sum9[8]; // RULE17
				flags_out.v = (a[7] == b[7]) & (sum9[7] != a[7]); // RULE9
			end
			ALU_SUB: begin
				res = dif9[7:0];
				flags_out.c = dif9[8]; // RULE17
				flags_out.v = (a[7] ^ b[7]) & (a[7] ^ dif9[7]); // RULE9
			end
			ALU_DADJ: begin
				res = a + dadj_add; // RULE11
				flags_out.c = dadj_hi; // RULE11
			end
			ALU_LD8: begin
				flags_out.v = 1'b0;
			end
			ALU_SHL: begin
				res = {a[6:0], 1'b0};
				flags_out.c = a[7]; // RULE17
				flags_out.v = a[7] ^ a[6];
			end
			ALU_SHR: begin
				res = {1'b0, a[7:1]};
				flags_out.c = a[0]; // RULE17
				flags_out.v = a[0];
			end
			ALU_BTST: begin
				flags_out.c = a[b[2:0]]; // RULE17
			end
			default: begin
				res = a;
			end
		endcase
		// Sign and zero of the result
		if (op == ALU_LD16) begin
			flags_out.v = 1'b0;
			flags_out.n = w[15]; // RULE15
			flags_out.z = (w == 16'h0000); // RULE16
		end else if (op != ALU_NONE && op != ALU_BTST) begin
			flags_out.n = res[7]; // RULE15
			flags_out.z = (res == 8'h00); // RULE16
		end
	end
endmodule
`default_nettype wire

// *** cpf_ea_unit.sv ***
// Effective operand address for one addressing mode
`timescale 1ns/1ps
`default_nettype none
module cpf_ea_unit import cpf_pkg::*; (
	input wire cpf_mode_e mode,
	input wire logic [15:0] hx,
	input wire logic [15:0] sp,
	input wire logic [15:0] pc,
	input wire logic [7:0] off8,
	input wire logic [15:0] off16,
	output logic [15:0] addr,
	output logic post_inc
);
	// Offsets widened for the adders
	wire [15:0] zext8 = {8'h00, off8};
	wire [15:0] sext8 = {{8{off8[7]}}, off8};

	// Address per mode in the one 16-bit space
	always_comb begin
		post_inc = 1'b0;
		case (mode)
			AM_DIR: addr = zext8; // RULE18
			AM_EXT: addr = off16;
			AM_IX: addr = hx;
			AM_IXP: begin
				addr = hx;
				post_inc = 1'b1;
			end
			AM_IX1: addr = hx + zext8;
			AM_IX1P: begin
				addr = hx + zext8;
				post_inc = 1'b1;
			end
			AM_IX2: addr = hx + off16;
			AM_SP1: addr = sp + zext8;
			AM_SP2: addr = sp + off16;
			AM_REL: addr = pc + sext8; // RULE22
			default: addr = off16;
		endcase
	end
endmodule
`default_nettype wire

// *** cpf_regs.sv ***
// Stack pointer, program counter, index and condition flags of the core
// Behaviour
// (RULE1) Stack pointer: 16 bits, next free slot
// (RULE2) Stack adjust adds sign-extended 8-bit immediate
// (RULE3) Reset loads stack pointer with 0x00ff
// (RULE4) Stack low reset touches low byte only
// (RULE5) Program counter increments on each fetch
// (RULE6) Change of flow loads non-sequential target
// (RULE7) Leaving reset loads vector, high first
// (RULE8) Flag bits 6 and 5 read one
// (RULE9) Overflow bit 7 on signed overflow
// (RULE10) Half carry bit 4 from bit 3
// (RULE11) Decimal adjust corrects using half, carry
// (RULE12) Mask bit 3 set blocks maskable interrupts
// (RULE13) Mask set after push, before service
// (RULE14) No interrupt right after mask clear
// (RULE15) Negative bit 2 copies result MSB
// (RULE16) Zero bit 1 on zero result
// (RULE17) Carry bit 0: carry, borrow, shift, test
// (RULE18) One 64-Kbyte space, 16-bit addresses
// (RULE19) Test branches: listed mode, relative target
// (RULE20) Moves: source mode and destination mode
// (RULE21) Reset clears index high byte only
// (RULE22) Relative branch adds sign-extended offset
// (RULE23) Flag writes keep fixed bits at one
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "cpf_consts.svh"
module cpf_regs import cpf_pkg::*; (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire cpf_cmd_s cmd,
	input wire logic irq_req,
	input wire logic [7:0] mem_rdata,
	output logic [15:0] mem_addr,
	output logic mem_rd,
	input wire logic [7:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [31:0] bus_rdata,
	output cpf_view_s view,
	output logic irq_take
);

	// Register port address decode, used by read and write paths
	function automatic cpf_sel_e reg_sel(input logic [7:0] addr);
		case (addr)
			`CPF_OFS_SP: reg_sel = SEL_SP;
			`CPF_OFS_PC: reg_sel = SEL_PC;
			`CPF_OFS_CCR: reg_sel = SEL_CCR;
			`CPF_OFS_HX: reg_sel = SEL_HX;
			`CPF_OFS_STAT: reg_sel = SEL_STAT;
			default: reg_sel = SEL_NONE;
		endcase
	endfunction

	// Reset vector fetch sequencer states
	typedef enum logic [1:0] {
		VEC_HI, VEC_LO, VEC_LOAD, VEC_RUN
	} cpf_vec_e;

	// Architectural registers
	logic [15:0] sp_q; // Stack pointer
	logic [15:0] sp_d;
	logic [15:0] pc_q; // Program counter
	logic [15:0] pc_d;
	logic [7:0] ccr_q; // Condition flags
	logic [7:0] ccr_d;
	logic [7:0] h_q; // Index high byte
	logic [7:0] h_d;
	logic [7:0] x_q; // Index low byte, no reset
	logic [7:0] x_d;
	logic [7:0] vec_hi_q; // Captured vector high byte
	logic irq_hold_q; // One boundary of interrupt shadow
	logic irq_hold_d;
	logic [31:0] rdata_q; // Registered read data
	logic [31:0] rdata_d;
	cpf_vec_e vec_q; // Vector fetch state
	cpf_vec_e vec_d;

	// Bus decode
	wire cpf_sel_e wr_sel = reg_sel(bus_addr);
	wire cpf_sel_e rd_sel = reg_sel(bus_addr);
	wire wr_sp = bus_wr & (wr_sel == SEL_SP);
	wire wr_pc = bus_wr & (wr_sel == SEL_PC);
	wire wr_ccr = bus_wr & (wr_sel == SEL_CCR);
	wire wr_hx = bus_wr & (wr_sel == SEL_HX);

	// Sequencer status
	wire vec_busy = (vec_q != VEC_RUN);
	wire [15:0] hx = {h_q, x_q};

	// Sign-extended immediate for stack adjust
	wire [15:0] imm_sext = {{8{cmd.imm8[7]}}, cmd.imm8};

	// Operand addresses for test branches and moves
	wire [15:0] src_addr;
	wire [15:0] dst_addr;
	wire [15:0] rel_target;
	wire src_inc;
	wire dst_inc;

	// Source or tested operand, in its listed mode
	cpf_ea_unit u_src_ea (
		.mode(cmd.src_mode),
		.hx(hx),
		.sp(sp_q),
		.pc(pc_q),
		.off8(cmd.imm8),
		.off16(cmd.imm16),
		.addr(src_addr),
		.post_inc(src_inc)
	); // RULE19 RULE20

	// Destination operand, its own mode
	cpf_ea_unit u_dst_ea (
		.mode(cmd.dst_mode),
		.hx(hx),
		.sp(sp_q),
		.pc(pc_q),
		.off8(cmd.dst_off8),
		.off16(cmd.imm16),
		.addr(dst_addr),
		.post_inc(dst_inc)
	); // RULE20

	// Branch target is always relative to the program counter
	cpf_ea_unit u_rel_ea (
		.mode(AM_REL),
		.hx(hx),
		.sp(sp_q),
		.pc(pc_q),
		.off8(cmd.imm8),
		.off16(cmd.imm16),
		.addr(rel_target),
		.post_inc()
	); // RULE19 RULE22

	// Index advances after a post-increment operand is used
	wire hx_inc = cmd.ea_done & (src_inc | dst_inc);
	wire [15:0] hx_next = hx + 16'h0001;

	// Arithmetic and flags
	wire [7:0] alu_res;
	wire cpf_flags_s flags_in;
	wire cpf_flags_s flags_new;
	assign flags_in = '{v: ccr_q[`CPF_BIT_V], h: ccr_q[`CPF_BIT_H],
		n: ccr_q[`CPF_BIT_N], z: ccr_q[`CPF_BIT_Z], c: ccr_q[`CPF_BIT_C]};

	cpf_flag_unit u_flags (
		.op(cmd.alu_op),
		.a(cmd.alu_a),
		.b(cmd.alu_b),
		.w(cmd.alu_w),
		.flags_in(flags_in),
		.res(alu_res),
		.flags_out(flags_new)
	);

	// Mask clear request from a flag transfer or explicit clear
	wire tap_clears = cmd.ccr_load & ccr_q[`CPF_BIT_I] & ~cmd.ccr_wdata[`CPF_BIT_I];
	wire mask_cleared = cmd.mask_clear | tap_clears;

	// Maskable interrupt acceptance at a boundary
	assign irq_take = irq_req & ~ccr_q[`CPF_BIT_I] & ~irq_hold_q & cmd.boundary
		& ~vec_busy; // RULE12 RULE14

	// Vector fetch memory port
	always_comb begin
		mem_rd = 1'b0;
		mem_addr = pc_q; // RULE18
		case (vec_q)
			VEC_HI: begin
				mem_rd = 1'b1;
				mem_addr = `CPF_VEC_HI; // RULE7
			end
			VEC_LO: begin
				mem_rd = 1'b1;
				mem_addr = `CPF_VEC_LO; // RULE7
			end
			default: begin
				mem_rd = 1'b0;
			end
		endcase
	end

	// Vector fetch next state
	always_comb begin
		case (vec_q)
			VEC_HI: vec_d = VEC_LO;
			VEC_LO: vec_d = VEC_LOAD;
			VEC_LOAD: vec_d = VEC_RUN;
			VEC_RUN: vec_d = VEC_RUN;
			default: vec_d = VEC_RUN;
		endcase
	end

	// Stack pointer next value, core operations before bus writes
	always_comb begin
		sp_d = sp_q;
		if (cmd.sp_adjust) begin
			sp_d = sp_q + imm_sext; // RULE2
		end else if (cmd.sp_low_reset) begin
			sp_d = {sp_q[15:8], `CPF_SP_LOW_RESET}; // RULE4
		end else if (cmd.sp_push) begin
			sp_d = sp_q - 16'h0001; // RULE1
		end else if (cmd.sp_pull) begin
			sp_d = sp_q + 16'h0001; // RULE1
		end else if (wr_sp) begin
			sp_d = bus_wdata[15:0];
		end
	end

	// Program counter next value
	always_comb begin
		pc_d = pc_q;
		if (vec_q == VEC_LOAD) begin
			pc_d = {vec_hi_q, mem_rdata}; // RULE7
		end else if (vec_busy) begin
			pc_d = pc_q;
		end else if (cmd.cof_load) begin
			pc_d = cmd.cof_target; // RULE6
		end else if (cmd.rel_take) begin
			pc_d = rel_target; // RULE6 RULE22
		end else if (cmd.fetch) begin
			pc_d = pc_q + 16'h0001; // RULE5
		end else if (wr_pc) begin
			pc_d = bus_wdata[15:0];
		end
	end

	// Condition flags next value
	always_comb begin
		ccr_d = ccr_q;
		if (cmd.ccr_load) begin
			ccr_d = cmd.ccr_wdata;
		end else if (cmd.alu_op != ALU_NONE) begin
			ccr_d[`CPF_BIT_V] = flags_new.v; // RULE9
			ccr_d[`CPF_BIT_H] = flags_new.h; // RULE10
			ccr_d[`CPF_BIT_N] = flags_new.n; // RULE15
			ccr_d[`CPF_BIT_Z] = flags_new.z; // RULE16
			ccr_d[`CPF_BIT_C] = flags_new.c; // RULE17
		end else if (wr_ccr) begin
			ccr_d = bus_wdata[7:0];
		end
		// Mask clear, then set, so a set in the same cycle wins
		if (cmd.mask_clear) begin
			ccr_d[`CPF_BIT_I] = 1'b0; // RULE12
		end
		if (cmd.mask_set | cmd.irq_pushed) begin
			ccr_d[`CPF_BIT_I] = 1'b1; // RULE13
		end
		ccr_d = ccr_d | `CPF_CCR_ONES; // RULE8 RULE23
	end

	// Interrupt shadow after a mask clear, dropped at next boundary
	always_comb begin
		irq_hold_d = irq_hold_q;
		if (cmd.boundary) begin
			irq_hold_d = 1'b0;
		end
		if (mask_cleared) begin
			irq_hold_d = 1'b1; // RULE14
		end
	end

	// Index register next values
	always_comb begin
		h_d = h_q;
		x_d = x_q;
		if (hx_inc) begin
			h_d = hx_next[15:8];
			x_d = hx_next[7:0];
		end else begin
			if (cmd.h_load) begin
				h_d = cmd.h_wdata;
			end else if (wr_hx) begin
				h_d = bus_wdata[15:8];
			end
			if (cmd.x_load) begin
				x_d = cmd.x_wdata;
			end else if (wr_hx) begin
				x_d = bus_wdata[7:0];
			end
		end
	end

	// Read data selection, unmapped reads as zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (bus_rd) begin
			case (rd_sel)
				SEL_SP: rdata_d = {16'h0000, sp_q};
				SEL_PC: rdata_d = {16'h0000, pc_q};
				SEL_CCR: rdata_d = {24'h00_0000, ccr_q}; // RULE8
				SEL_HX: rdata_d = {16'h0000, hx};
				SEL_STAT: begin
					rdata_d[`CPF_STAT_VEC_BUSY] = vec_busy;
					rdata_d[`CPF_STAT_IRQ_HOLD] = irq_hold_q;
					rdata_d[`CPF_STAT_IRQ_TAKE] = irq_req & ~ccr_q[`CPF_BIT_I];
				end
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Pointer registers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sp_q <= `CPF_SP_RESET; // RULE3
			pc_q <= 16'h0000;
		end else begin
			sp_q <= sp_d;
			pc_q <= pc_d;
		end
	end

	// Flags, index high byte and shadow
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ccr_q <= `CPF_CCR_RESET;
			h_q <= `CPF_H_RESET; // RULE21
			irq_hold_q <= 1'b0;
		end else begin
			ccr_q <= ccr_d;
			h_q <= h_d;
			irq_hold_q <= irq_hold_d;
		end
	end

	// Index low byte keeps its contents through reset
	always_ff @(posedge clk_sys) begin
		x_q <= x_d; // RULE21
	end

	// Vector sequencer and captured high byte
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			vec_q <= VEC_HI;
			vec_hi_q <= 8'h00;
		end else begin
			vec_q <= vec_d;
			if (vec_q == VEC_LO) begin
				vec_hi_q <= mem_rdata; // RULE7
			end
		end
	end

	// Read data register
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Outputs
	assign bus_rdata = rdata_q;
	assign view = '{pc: pc_q, sp: sp_q, condition_flags_reg: ccr_q, hx: hx, alu_res: alu_res,
		src_addr: src_addr, dst_addr: dst_addr, vec_busy: vec_busy};

endmodule
`default_nettype wire

// *** cpf_regs_props.sv ***
// Concurrent checks on the pointer and flag register block
`timescale 1ns/1ps
`default_nettype none
`include "cpf_consts.svh"
module cpf_regs_props import cpf_pkg::*; (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire cpf_cmd_s cmd,
	input wire logic irq_req,
	input wire logic [7:0] mem_rdata,
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd,
	input wire logic [7:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [31:0] bus_rdata,
	input wire cpf_view_s view,
	input wire logic irq_take
);
	// Helper taps for past values
	logic [15:0] sx, tgt, sp, pc;
	logic [7:0] sp_hi, condition_flags_reg;
	assign sx = {{8{cmd.imm8[7]}}, cmd.imm8};
	assign tgt = cmd.cof_target;
	assign sp = view.sp;
	assign pc = view.pc;
	assign sp_hi = view.sp[15:8];
	assign condition_flags_reg = view.condition_flags_reg;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	property p_sp_adj;
		cmd.sp_adjust |=> sp == $past(sp) + $past(sx);
	endproperty
	a_sp_adj: assert property (p_sp_adj) else $error("stack adjust sum wrong");
	property p_sp_low;
		cmd.sp_low_reset && !cmd.sp_adjust |=> sp == {$past(sp_hi), 8'hff};
	endproperty
	a_sp_low: assert property (p_sp_low) else $error("stack low reset wrong");
	property p_ones;
		condition_flags_reg[6:5] == 2'b11;
	endproperty
	a_ones: assert property (p_ones) else $error("fixed flag bits not one");
	property p_fetch;
		cmd.fetch && !cmd.cof_load && !cmd.rel_take && !view.vec_busy |=> pc == $past(pc) + 16'h0001;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch step wrong");
	property p_cof;
		cmd.cof_load && !view.vec_busy |=> pc == $past(tgt);
	endproperty
	a_cof: assert property (p_cof) else $error("flow target not loaded");
	property p_rel;
		cmd.rel_take && !cmd.cof_load && !view.vec_busy |=> pc == $past(pc) + $past(sx);
	endproperty
	a_rel: assert property (p_rel) else $error("relative target wrong");
	property p_vec;
		// Sampled reset keeps the release edge itself out of the antecedent
		arst_n && mem_rd && mem_addr == `CPF_VEC_HI |=> mem_rd && mem_addr == `CPF_VEC_LO
			##2 pc == {$past(mem_rdata, 2), $past(mem_rdata, 1)};
	endproperty
	a_vec: assert property (p_vec) else $error("vector load wrong");
	property p_mask;
		irq_take |-> !condition_flags_reg[`CPF_BIT_I] && irq_req && cmd.boundary;
	endproperty
	a_mask: assert property (p_mask) else $error("masked interrupt taken");
	property p_shadow;
		cmd.mask_clear && condition_flags_reg[`CPF_BIT_I] && !cmd.mask_set && !cmd.irq_pushed |=> !irq_take;
	endproperty
	a_shadow: assert property (p_shadow) else $error("interrupt right after unmask");
	property p_pushed;
		cmd.irq_pushed |=> condition_flags_reg[`CPF_BIT_I];
	endproperty
	a_pushed: assert property (p_pushed) else $error("mask not set on entry");
	property p_ccr_rd;
		bus_rd && bus_addr == `CPF_OFS_CCR |=> bus_rdata == {24'h0, $past(condition_flags_reg)};
	endproperty
	a_ccr_rd: assert property (p_ccr_rd) else $error("flag read wrong");
	// Main scenarios reached
	c_vec: cover property (mem_rd && mem_addr == `CPF_VEC_LO);
	c_irq: cover property (irq_take);
	c_rel: cover property (cmd.rel_take && !view.vec_busy);
endmodule
bind cpf_regs cpf_regs_props u_props (.clk_sys(clk_sys), .arst_n(arst_n), .cmd(cmd),
	.irq_req(irq_req), .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd),
	.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
	.bus_rdata(bus_rdata), .view(view), .irq_take(irq_take));
`default_nettype wire

// *** cpf_mem_model.sv ***
// Behavioural program memory answering the core's reads
`timescale 1ns/1ps
`default_nettype none
`include "cpf_consts.svh"
module cpf_mem_model #(
	parameter logic [15:0] VEC = 16'h8000
) (
	input wire logic clk_sys,
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	output logic [7:0] mem_rdata
);
	logic [7:0] data_q;
	// Byte stands one cycle after the read, then the bus drifts
	always_ff @(posedge clk_sys) begin
		if (mem_rd) begin
			data_q <= (mem_addr == `CPF_VEC_HI) ? VEC[15:8] :
				(mem_addr == `CPF_VEC_LO) ? VEC[7:0] : mem_addr[7:0];
		end else begin
			data_q <= ~data_q;
		end
	end
	assign mem_rdata = data_q;
endmodule
`default_nettype wire

// *** cpf_regs_tb_top.sv ***
// Self-checking bench for the pointer and flag register block
`timescale 1ns/1ps
`default_nettype none
`include "cpf_consts.svh"
module cpf_regs_tb_top import cpf_pkg::*;;
	localparam logic [15:0] VEC = 16'h8000;
	logic clk_sys, arst_n, irq_req, mem_rd, bus_wr, bus_rd, irq_take;
	logic [7:0] mem_rdata, bus_addr;
	logic [15:0] mem_addr;
	logic [31:0] bus_wdata, bus_rdata;
	cpf_cmd_s cmd, c;
	cpf_view_s view;
	int n_mismatch, n_tests;
	// One flag case: op, operands, result, flags {V,H,N,Z,C}, mask
	typedef struct {cpf_alu_e op; logic [7:0] a, b, r; logic [4:0] f, m;} cpf_row_s;
	cpf_row_s rows[12] = '{
		'{ALU_ADD, 8'h08, 8'h08, 8'h10, 5'h08, 5'h1f},
		'{ALU_ADD, 8'h7f, 8'h01, 8'h80, 5'h1c, 5'h1f},
		'{ALU_ADD, 8'hff, 8'h01, 8'h00, 5'h0b, 5'h1f},
		'{ALU_ADC, 8'h01, 8'h01, 8'h03, 5'h00, 5'h1f},
		'{ALU_SUB, 8'h80, 8'h01, 8'h7f, 5'h10, 5'h17},
		'{ALU_SUB, 8'h00, 8'h01, 8'hff, 5'h05, 5'h17},
		'{ALU_LD8, 8'h00, 8'h00, 8'h00, 5'h02, 5'h16},
		'{ALU_ADD, 8'h09, 8'h08, 8'h11, 5'h08, 5'h1f},
		'{ALU_DADJ, 8'h11, 8'h00, 8'h17, 5'h00, 5'h07},
		'{ALU_SHL, 8'h81, 8'h00, 8'h02, 5'h11, 5'h17},
		'{ALU_SHR, 8'h01, 8'h00, 8'h00, 5'h13, 5'h17},
		'{ALU_BTST, 8'h04, 8'h02, 8'h00, 5'h01, 5'h01}};
	cpf_regs dut (.clk_sys(clk_sys), .arst_n(arst_n), .cmd(cmd), .irq_req(irq_req),
		.mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.view(view), .irq_take(irq_take));
	cpf_mem_model #(.VEC(VEC)) u_mem (.clk_sys(clk_sys), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_rdata(mem_rdata));
	// Free-running system clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// Compare and count
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	// One sequencer command cycle
	task put(input cpf_cmd_s x, input logic irq = 1'b0);
		@(posedge clk_sys);
		cmd <= x;
		irq_req <= irq;
		#1;
	endtask
	// Register port write
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk_sys);
		bus_wr <= 1'b0;
	endtask
	// Register port read, data looked at in its one cycle
	task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge clk_sys);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clk_sys);
		bus_rd <= 1'b0;
		#1;
		chk(nm, e, bus_rdata);
	endtask
	// Counts and verdict
	task give_verdict;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Hang guard, about ten times the expected run
	initial begin
		#40000;
		n_mismatch++;
		give_verdict;
	end
	// Main sequence
	initial begin
		arst_n = 1'b0;
		cmd = '0;
		c = '0;
		irq_req = 1'b0;
		bus_addr = 8'h00;
		bus_wdata = 32'h0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		repeat (20) @(posedge clk_sys);
		chk("sp in reset", 16'h00ff, view.sp);
		chk("ccr in reset", 8'h68, view.condition_flags_reg);
		chk("h in reset", 8'h00, view.hx[15:8]);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
		chk("pc vector", VEC, view.pc);
		rd(`CPF_OFS_SP, 32'h00ff, "sp read");
		$display("test reset done");
		// Flag table
		foreach (rows[i]) begin
			c = '0;
			c.alu_op = rows[i].op;
			c.alu_a = rows[i].a;
			c.alu_b = rows[i].b;
			put(c);
			if (rows[i].op != ALU_BTST) chk("alu res", rows[i].r, view.alu_res);
			put('0);
			chk("flags", rows[i].f, {view.condition_flags_reg[7], view.condition_flags_reg[4], view.condition_flags_reg[2:0]} & rows[i].m);
		end
		$display("test flags done");
		// Flag writes keep fixed ones; unmapped reads zero
		wr(`CPF_OFS_CCR, 32'h0);
		rd(`CPF_OFS_CCR, 32'h60, "ccr write zero");
		rd(8'h14, 32'h0, "unmapped");
		c = '0;
		c.ccr_load = 1'b1;
		put(c);
		put('0);
		chk("ccr load zero", 8'h60, view.condition_flags_reg);
		$display("test regs done");
		// Stack pointer low reset and adjust
		wr(`CPF_OFS_SP, 32'h1234);
		c = '0;
		c.sp_low_reset = 1'b1;
		put(c);
		c = '0;
		c.sp_adjust = 1'b1;
		c.imm8 = 8'h80;
		put(c);
		chk("sp low", 16'h12ff, view.sp);
		c.imm8 = 8'h7f;
		put(c);
		chk("sp minus", 16'h127f, view.sp);
		put('0);
		chk("sp plus", 16'h12fe, view.sp);
		c = '0;
		c.sp_push = 1'b1;
		put(c);
		c.sp_push = 1'b0;
		c.sp_pull = 1'b1;
		put(c);
		chk("sp push", 16'h12fd, view.sp);
		put('0);
		chk("sp pull", 16'h12fe, view.sp);
		$display("test stack done");
		// Program counter: fetches, jump, relative back
		c = '0;
		c.fetch = 1'b1;
		repeat (3) put(c);
		c.cof_load = 1'b1;
		c.cof_target = 16'h4321;
		put(c);
		chk("pc fetch", VEC + 16'h0003, view.pc);
		c = '0;
		c.fetch = 1'b1;
		c.rel_take = 1'b1;
		c.imm8 = 8'hfe;
		put(c);
		chk("pc jump", 16'h4321, view.pc);
		put('0);
		chk("pc rel", 16'h431f, view.pc);
		$display("test pc done");
		// Operand addresses and post increment
		wr(`CPF_OFS_HX, 32'h1234);
		c = '0;
		c.src_mode = AM_DIR;
		c.imm8 = 8'h9a;
		c.dst_mode = AM_IXP;
		c.ea_done = 1'b1;
		put(c);
		chk("src dir", 16'h009a, view.src_addr);
		chk("dst ix", 16'h1234, view.dst_addr);
		c = '0;
		c.src_mode = AM_EXT;
		c.imm16 = 16'hffff;
		c.dst_mode = AM_SP2;
		put(c);
		chk("hx inc", 16'h1235, view.hx);
		chk("dst sp2", 16'h12fd, view.dst_addr);
		chk("src ext", 16'hffff, view.src_addr);
		$display("test address done");
		// Mask set first, then shadow after unmask, then entry sets mask
		c = '0;
		c.mask_set = 1'b1;
		put(c);
		c = '0;
		c.boundary = 1'b1;
		put(c, 1'b1);
		chk("masked take", 1'b0, irq_take);
		c = '0;
		c.mask_clear = 1'b1;
		put(c, 1'b1);
		c = '0;
		c.boundary = 1'b1;
		put(c, 1'b1);
		chk("shadow take", 1'b0, irq_take);
		c.irq_pushed = 1'b1;
		put(c, 1'b1);
		chk("open take", 1'b1, irq_take);
		put('0);
		chk("mask set", 1'b1, view.condition_flags_reg[`CPF_BIT_I]);
		$display("test interrupt done");
		// Reset in mid-run
		arst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("sp again", 16'h00ff, view.sp);
		chk("hx again", 16'h0035, view.hx);
		arst_n <= 1'b1;
		rd(`CPF_OFS_STAT, 32'h1, "vector busy");
		repeat (2) @(posedge clk_sys);
		#1;
		chk("pc again", VEC, view.pc);
		$display("test rerun done");
		give_verdict;
	end
endmodule
`default_nettype wire
